/* File: rtl/psl_defs.vh */
`ifndef PSL_DEFS_VH
`define PSL_DEFS_VH

// Register byte offsets
`define PSL_CTRL_OFS        12'h000
`define PSL_STATUS_OFS      12'h004
`define PSL_ERRCNT_OFS      12'h008

// Control field positions and reset value
`define PSL_CTRL_BYPASS     0
`define PSL_CTRL_FDX        1
`define PSL_CTRL_HOLD       2
`define PSL_CTRL_RST        8'h00

// Status field positions
`define PSL_ST_RMII         0
`define PSL_ST_TEST         1
`define PSL_ST_REPEATER     2
`define PSL_ST_DRIVE        3
`define PSL_ST_EMPTY        4
`define PSL_ST_FULL         5

// Pin order inside the strap vector
`define PSL_PIN_ER          0
`define PSL_PIN_DV          1
`define PSL_PIN_COL         2

// Strap capture timing
`define PSL_SETTLE_CYCLES   4'h4

// Receive buffer shape
`define PSL_FIFO_WIDTH      5
`define PSL_FIFO_DEPTH      8
`define PSL_FIFO_AW         3

`define PSL_ERRCNT_W        16

`endif

/* File: rtl/psl_fifo.v */
`timescale 1ns/1ns
`default_nettype none
module psl_fifo #(
	parameter W  = 5,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          in_valid,
	output reg           in_ready,
	input  wire [W-1:0]  in_data,
	output reg           out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);
	reg  [W-1:0]  mem [0:D-1];
	reg  [AW-1:0] wr_ptr_reg;
	reg  [AW-1:0] rd_ptr_reg;
	reg  [AW:0]   count_reg;
	reg  [AW:0]   count_next;
	wire          push;
	wire          pop;

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem[rd_ptr_reg];

	always @* begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + 1'b1;
		else if (pop & ~push)
			count_next = count_reg - 1'b1;
	end

	// Flags are registered so the ready seen upstream is a clean flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			in_ready   <= 1'b0;
			out_valid  <= 1'b0;
		end else begin
			count_reg <= count_next;
			in_ready  <= (count_next != D[AW:0]);
			out_valid <= (count_next != {(AW+1){1'b0}});
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
		end
	end

	// Storage carries no reset; only the pointers define content
	always @(posedge pclk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end
endmodule
`default_nettype wire

/* File: rtl/psl_rx_status.v */
`include "psl_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module psl_rx_status (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        sym_valid,
	input  wire [4:0]  sym_code,
	output wire        sym_ready,
	input  wire        col_event,
	output reg  [3:0]  rxd,
	output reg         rx_dv_out,
	output reg         rx_dv_oe,
	input  wire        rx_dv_in,
	output reg         rx_er_out,
	output reg         rx_er_oe,
	input  wire        rx_er_in,
	output reg         col_out,
	output reg         col_oe,
	input  wire        col_in
);
	localparam ST_SETTLE  = 2'd0;
	localparam ST_CAPTURE = 2'd1;
	localparam ST_RUN     = 2'd2;

	reg  [1:0]                 state_reg;
	reg  [1:0]                 state_next;
	reg  [3:0]                 settle_reg;
	reg  [3:0]                 settle_next;
	reg  [2:0]                 pin_s1_reg;
	reg  [2:0]                 pin_s2_reg;
	reg  [2:0]                 pin_s3_reg;
	reg                        rmii_strap_reg;
	reg                        test_enable_strap_reg;
	reg                        repeater_strap_reg;
	reg                        drive_reg;
	reg  [7:0]                 ctrl_reg;
	reg  [`PSL_ERRCNT_W-1:0]   errcnt_reg;
	reg  [`PSL_ERRCNT_W-1:0]   errcnt_next;
	wire                       symbol_decoder_bypass;
	wire                       full_duplex;
	wire                       rx_hold;
	wire                       fifo_out_valid;
	wire                       fifo_out_ready;
	wire [4:0]                 fifo_out_data;
	wire                       pop;
	wire [4:0]                 dec;
	wire                       setup_phase;
	wire                       access_done;
	wire                       wr_done;
	wire                       sym_bad;
	wire [2:0]                 pin_raw;
	genvar                     gi;

	assign symbol_decoder_bypass = ctrl_reg[`PSL_CTRL_BYPASS];
	assign full_duplex           = ctrl_reg[`PSL_CTRL_FDX];
	assign rx_hold               = ctrl_reg[`PSL_CTRL_HOLD];

	// 4B/5B data code groups; bit 4 of the result flags an invalid group
	function [4:0] dec_4b5b;
		input [4:0] code;
		begin
			case (code)
				5'h1e:   dec_4b5b = 5'h00;
				5'h09:   dec_4b5b = 5'h01;
				5'h14:   dec_4b5b = 5'h02;
				5'h15:   dec_4b5b = 5'h03;
				5'h0a:   dec_4b5b = 5'h04;
				5'h0b:   dec_4b5b = 5'h05;
				5'h0e:   dec_4b5b = 5'h06;
				5'h0f:   dec_4b5b = 5'h07;
				5'h12:   dec_4b5b = 5'h08;
				5'h13:   dec_4b5b = 5'h09;
				5'h16:   dec_4b5b = 5'h0a;
				5'h17:   dec_4b5b = 5'h0b;
				5'h1a:   dec_4b5b = 5'h0c;
				5'h1b:   dec_4b5b = 5'h0d;
				5'h1c:   dec_4b5b = 5'h0e;
				5'h1d:   dec_4b5b = 5'h0f;
				default: dec_4b5b = 5'h10;
			endcase
		end
	endfunction

	// Address decode shared by the write strobe and the slave error
	function mapped;
		input [11:0] addr;
		begin
			mapped = (addr == `PSL_CTRL_OFS) || (addr == `PSL_STATUS_OFS) ||
				(addr == `PSL_ERRCNT_OFS);
		end
	endfunction

	// Status layout follows the field positions, so moving a bit touches only the header
	function [31:0] status_word;
		input rmii;
		input test;
		input rep;
		input drv;
		input empty;
		input full;
		begin
			status_word                   = 32'h0;
			status_word[`PSL_ST_RMII]     = rmii;
			status_word[`PSL_ST_TEST]     = test;
			status_word[`PSL_ST_REPEATER] = rep;
			status_word[`PSL_ST_DRIVE]    = drv;
			status_word[`PSL_ST_EMPTY]    = empty;
			status_word[`PSL_ST_FULL]     = full;
		end
	endfunction

	// Strap pins are asynchronous to pclk; three stages, accept when stages 2 and 3 agree
	assign pin_raw[`PSL_PIN_ER]  = rx_er_in;
	assign pin_raw[`PSL_PIN_DV]  = rx_dv_in;
	assign pin_raw[`PSL_PIN_COL] = col_in;

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_s1_reg[gi] <= 1'b0;
					pin_s2_reg[gi] <= 1'b0;
					pin_s3_reg[gi] <= 1'b0;
				end else begin
					pin_s1_reg[gi] <= pin_raw[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
					pin_s3_reg[gi] <= pin_s2_reg[gi];
				end
			end
		end
	endgenerate

	// Capture sequence after reset release
	always @* begin
		state_next  = state_reg;
		settle_next = settle_reg;
		case (state_reg)
			ST_SETTLE: begin
				// Gives the strap resistors time to win over pins just released by reset
				settle_next = settle_reg + 1'b1;
				if (settle_reg == `PSL_SETTLE_CYCLES - 1'b1)
					state_next = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				// A strap that never settles keeps every driver off; there is no timeout
				if (pin_s2_reg == pin_s3_reg)
					state_next = ST_RUN;
			end
			ST_RUN: begin
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_SETTLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg             <= ST_SETTLE;
			settle_reg            <= 4'h0;
			rmii_strap_reg        <= 1'b0;
			test_enable_strap_reg <= 1'b0;
			repeater_strap_reg    <= 1'b0;
			drive_reg             <= 1'b0;
		end else begin
			state_reg  <= state_next;
			settle_reg <= settle_next;
			// Straps only load once, so later pin activity cannot disturb them
			if (state_reg == ST_CAPTURE && state_next == ST_RUN) begin
				rmii_strap_reg        <= pin_s3_reg[`PSL_PIN_COL];
				test_enable_strap_reg <= pin_s3_reg[`PSL_PIN_DV];
				repeater_strap_reg    <= pin_s3_reg[`PSL_PIN_ER];
				drive_reg             <= 1'b1;
			end
		end
	end

	psl_fifo #(
		.W  (`PSL_FIFO_WIDTH),
		.D  (`PSL_FIFO_DEPTH),
		.AW (`PSL_FIFO_AW)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (sym_valid),
		.in_ready  (sym_ready),
		.in_data   (sym_code),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// Nothing leaves the buffer before the straps are captured and the pins driven, or while software holds it
	assign fifo_out_ready = drive_reg & ~rx_hold;
	assign pop            = fifo_out_valid & fifo_out_ready;
	assign dec            = dec_4b5b(fifo_out_data);
	assign sym_bad        = pop & ~symbol_decoder_bypass & dec[4];

	// Enables follow the capture flag, so reset time leaves all shared pins as inputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_dv_oe <= 1'b0;
			rx_er_oe <= 1'b0;
			col_oe   <= 1'b0;
		end else begin
			rx_dv_oe <= drive_reg;
			rx_er_oe <= drive_reg;
			col_oe   <= drive_reg;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd       <= 4'h0;
			rx_dv_out <= 1'b0;
			rx_er_out <= 1'b0;
			col_out   <= 1'b0;
		end else begin
			rx_dv_out <= pop;
			if (pop)
				rxd <= symbol_decoder_bypass ? fifo_out_data[3:0] : dec[3:0];
			else
				rxd <= 4'h0;
			if (symbol_decoder_bypass)
				rx_er_out <= pop & fifo_out_data[4];
			else
				rx_er_out <= sym_bad;
			// Full duplex keeps the collision pin low
			col_out <= drive_reg & col_event & ~full_duplex;
		end
	end

	// APB slave: one wait state, so read data comes from a flop
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_done     = access_done & pwrite & mapped(paddr);

	always @* begin
		errcnt_next = errcnt_reg;
		if (wr_done && paddr == `PSL_ERRCNT_OFS)
			errcnt_next = {`PSL_ERRCNT_W{1'b0}};
		// A bad symbol in the clearing cycle still counts
		if (sym_bad && errcnt_next != {`PSL_ERRCNT_W{1'b1}})
			errcnt_next = errcnt_next + 1'b1;
	end

	// Saturating, so a long error burst reads as full scale instead of wrapping
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			errcnt_reg <= {`PSL_ERRCNT_W{1'b0}};
		else
			errcnt_reg <= errcnt_next;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped(paddr);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel & penable & ~pready & ~pwrite) begin
			case (paddr)
				`PSL_CTRL_OFS:   prdata <= {24'h0, ctrl_reg};
				`PSL_STATUS_OFS: prdata <= status_word(rmii_strap_reg, test_enable_strap_reg,
					repeater_strap_reg, drive_reg, ~fifo_out_valid, ~sym_ready);
				`PSL_ERRCNT_OFS: prdata <= {16'h0, errcnt_reg};
				default:         prdata <= 32'h0;
			endcase
		end else if (setup_phase) begin
			prdata <= 32'h0;
		end
	end

	// Only the low byte lane carries control bits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_reg <= `PSL_CTRL_RST;
		else if (wr_done && paddr == `PSL_CTRL_OFS && pstrb[0])
			ctrl_reg <= {5'h0, pwdata[2:0]};
	end
endmodule
`default_nettype wire

/* File: sim/psl_mac_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Strap resistors on the far side; a released pin settles to its resistor level
module psl_mac_model (
	input  wire logic [2:0] strap,
	input  wire logic [2:0] out,
	input  wire logic [2:0] oe,
	output logic      [2:0] pin
);
	assign pin = (oe & out) | (~oe & strap);
endmodule
`default_nettype wire

/* File: sim/psl_rx_status_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module psl_rx_status_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       col_event,
	input wire logic       col_out,
	input wire logic       col_oe,
	input wire logic       rx_dv_oe,
	input wire logic       rx_er_oe,
	input wire logic       rx_dv_out,
	input wire logic       rx_er_out,
	input wire logic [3:0] rxd
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_oe_rst; !$past(presetn) |-> !(rx_dv_oe || rx_er_oe || col_oe); endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("driver on right after reset");
	property p_oe_hold; rx_dv_oe |=> rx_dv_oe; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("driver dropped");
	// Straps need a few settled cycles before the pins may turn round
	property p_oe_late; $rose(col_oe) |-> $past(presetn, 4); endproperty
	a_oe_late: assert property (p_oe_late) else $error("collision driver too early");
	property p_oe_pair; rx_er_oe == col_oe && rx_dv_oe == col_oe; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("enables disagree");
	property p_dv_drv; rx_dv_out |-> rx_dv_oe; endproperty
	a_dv_drv: assert property (p_dv_drv) else $error("valid while released");
	property p_rxd_idle; !rx_dv_out |-> rxd == 4'h0; endproperty
	a_rxd_idle: assert property (p_rxd_idle) else $error("nibble without valid");
	property p_er_dv; rx_er_out |-> rx_dv_out; endproperty
	a_er_dv: assert property (p_er_dv) else $error("error without nibble");
	property p_col; col_out |-> $past(col_event) && col_oe; endproperty
	a_col: assert property (p_col) else $error("collision without cause");
	property p_rdy; pready |-> $past(psel && penable) && !$past(pready); endproperty
	a_rdy: assert property (p_rdy) else $error("ready out of access phase");
	c_err: cover property (rx_dv_out && rx_er_out);
	c_col: cover property (col_out);
	c_oe: cover property ($rose(rx_dv_oe));
endmodule
bind psl_rx_status psl_rx_status_chk chk_u (.pclk, .presetn, .psel, .penable, .pready,
	.col_event, .col_out, .col_oe, .rx_dv_oe, .rx_er_oe, .rx_dv_out, .rx_er_out, .rxd);
`default_nettype wire

/* File: sim/tb_phy_rx_status_and_strap_latch.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_phy_rx_status_and_strap_latch;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sym_valid = 0;
	logic        pready, pslverr, sym_ready, e, col_event = 0;
	logic        rx_dv_out, rx_dv_oe, rx_er_out, rx_er_oe, col_out, col_oe;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0]  pstrb = 0, rxd;
	logic [4:0]  sym_code = 0;
	logic [2:0]  strap = 0, pin;
	logic [4:0]  enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	logic [10:0] rows [20];
	int          n_fail = 0, total_checks = 0, n;
	psl_rx_status dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .sym_valid, .sym_code, .sym_ready, .col_event, .rxd,
		.rx_dv_out, .rx_dv_oe, .rx_dv_in(pin[1]), .rx_er_out, .rx_er_oe, .rx_er_in(pin[0]),
		.col_out, .col_oe, .col_in(pin[2]));
	psl_mac_model mac_u (.strap, .out({col_out, rx_dv_out, rx_er_out}),
		.oe({col_oe, rx_dv_oe, rx_er_oe}), .pin);
	initial forever #2 pclk = ~pclk;
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
		if (pready !== 1'b1) n_fail++;
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wait_dv;
		n = 0;
		do @(posedge pclk); while (rx_dv_out !== 1'b1 && ++n < 20);
		if (rx_dv_out !== 1'b1) n_fail++;
	endtask
	task reset_to(input logic [2:0] s);
		strap <= s;
		presetn <= 0;
		repeat (6) @(posedge pclk);
		check({rx_dv_oe, rx_er_oe, col_oe}, 0);
		presetn <= 1;
		n = 0;
		do @(posedge pclk); while (rx_dv_oe !== 1'b1 && ++n < 30);
		check(rx_dv_oe, 1);
		apb(0, 12'h004, 0);
		check(r, {26'h0, 3'b011, s[0], s[1], s[2]});
	endtask
	task report_and_stop;
		$display("checks=%0d failures=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		for (int i = 0; i < 16; i++) rows[i] = {1'b0, enc[i], i[3:0], 1'b0};
		rows[16] = {1'b0, 5'h1f, 4'h0, 1'b1};
		rows[17] = {1'b0, 5'h04, 4'h0, 1'b1};
		rows[18] = {1'b1, 5'h1f, 4'hf, 1'b1};
		rows[19] = {1'b1, 5'h09, 4'h9, 1'b0};
		reset_to(3'b101);
		foreach (rows[i]) begin
			apb(1, 12'h000, {31'h0, rows[i][10]});
			sym_valid <= 1;
			sym_code <= rows[i][9:5];
			n = 0;
			do @(posedge pclk); while (sym_ready !== 1'b1 && ++n < 50);
			if (sym_ready !== 1'b1) n_fail++;
			sym_valid <= 0;
			wait_dv;
			check({rx_er_out, rxd}, {rows[i][0], rows[i][4:1]});
		end
		apb(0, 12'h008, 0);
		check(r, 2);
		apb(1, 12'h008, 0);
		apb(0, 12'h008, 0);
		check(r, 0);
		// Hold the drain so the buffer fills and must refuse the ninth symbol
		apb(1, 12'h000, 32'h4);
		sym_valid <= 1;
		n = 0;
		repeat (12) begin
			@(posedge pclk);
			if (sym_ready === 1'b1) n++;
		end
		sym_valid <= 0;
		check(n, 8);
		apb(0, 12'h004, 0);
		check(r, 32'h2d);
		apb(1, 12'h000, 0);
		n = 0;
		repeat (20) begin
			@(posedge pclk);
			if (rx_dv_out === 1'b1) n++;
		end
		check(n, 8);
		apb(1, 12'h004, 32'hffff_ffff);
		check(e, 0);
		apb(0, 12'h004, 0);
		check(r, 32'h1d);
		apb(0, 12'h00c, 0);
		check(e, 1);
		check(r, 0);
		col_event <= 1;
		repeat (2) @(posedge pclk);
		check(col_out, 1);
		apb(1, 12'h000, 32'h2);
		repeat (2) @(posedge pclk);
		check(col_out, 0);
		col_event <= 0;
		reset_to(3'b010);
		report_and_stop;
	end
endmodule
`default_nettype wire
